/* File: verilog/asr_regs.sv */
`timescale 1ns/1ps
module asr_regs #(
  parameter logic [15:0] PRODUCT_CODE = 16'h5a01, // arbitrary value
  parameter logic [15:0] MAKER_CODE   = 16'h7e33  // arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        csb_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        ref_in,
  input  wire logic [23:0] ref_edge_position_status,
  input  wire logic        timestamp_output_enable,
  input  wire logic        decimation_is_one,
  output logic             ref_receiver_enable,
  output logic             ref_processor_enable,
  output logic             ref_window_fine_steps,
  output logic [3:0]       ref_delay_select,
  output logic             device_clock_dc_pecl_mode,
  output logic             ref_input_dc_pecl_mode,
  output logic             ref_polarity_invert,
  output logic             ref_aligned,
  output logic             ref_timestamp_lsb
);
  logic        rst_meta_reg;
  logic        rst_s_n;
  logic        sclk_reg;
  logic        hdr_reg;
  logic        rw_reg;
  logic        fresh_reg;
  logic [3:0]  cnt_reg;
  logic [15:0] shift_reg;
  logic [7:0]  sdo_sh_reg;
  logic [14:0] addr_reg;
  logic [7:0]  config_reg;
  logic [7:0]  user_cfg_reg;
  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic        sdo_oe_reg;
  logic        sdo_reg;
  logic        rise;
  logic        fall;
  logic        hdr_end;
  logic        byte_end;
  logic        wr_stb;
  logic [7:0]  wdata;
  logic [14:0] hdr_addr;
  logic [14:0] addr_next;
  logic [7:0]  rd_byte;
  logic        hold;
  logic        ascend;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_s_n      <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_s_n      <= rst_meta_reg;
    end
  end

  // sclk is synchronous to mclk, so a registered copy suffices for edges
  assign rise     = !csb_n & sclk & !sclk_reg;
  assign fall     = !csb_n & !sclk & sclk_reg;
  assign hdr_end  = rise & !hdr_reg & (cnt_reg == asr_pkg::HDR_LAST);
  assign byte_end = rise & hdr_reg & (cnt_reg == asr_pkg::BYTE_LAST);
  assign hdr_addr = {shift_reg[13:0], sdi};
  assign wdata    = {shift_reg[6:0], sdi};
  assign wr_stb   = byte_end & !rw_reg;
  assign hold     = user_cfg_reg[asr_pkg::BIT_HOLD];
  assign ascend   = config_reg[asr_pkg::BIT_ASCEND];
  assign addr_next = hold ? addr_reg :
                     ascend ? addr_reg + 15'h0001 :
                     addr_reg - 15'h0001;

  // identity words come from constants, never from storage
  assign rd_byte =
    (addr_reg == asr_pkg::ADDR_CONFIG)   ?
      (config_reg | asr_pkg::CONFIG_RO_SET) :
    (addr_reg == asr_pkg::ADDR_PROD_LO)  ? PRODUCT_CODE[7:0] :
    (addr_reg == asr_pkg::ADDR_PROD_HI)  ? PRODUCT_CODE[15:8] :
    (addr_reg == asr_pkg::ADDR_MAKER_LO) ? MAKER_CODE[7:0] :
    (addr_reg == asr_pkg::ADDR_MAKER_HI) ? MAKER_CODE[15:8] :
    (addr_reg == asr_pkg::ADDR_USER_CFG) ? user_cfg_reg :
    (addr_reg == asr_pkg::ADDR_CTRL_A)   ? ctrl_a_reg :
    (addr_reg == asr_pkg::ADDR_CTRL_B)   ? ctrl_b_reg :
    (addr_reg == asr_pkg::ADDR_POS_0)    ?
      ref_edge_position_status[7:0] :
    (addr_reg == asr_pkg::ADDR_POS_1)    ?
      ref_edge_position_status[15:8] :
    (addr_reg == asr_pkg::ADDR_POS_2)    ?
      ref_edge_position_status[23:16] :
    8'h00;

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sclk_reg  <= 1'b0;
      hdr_reg   <= 1'b0;
      rw_reg    <= 1'b0;
      fresh_reg <= 1'b0;
      cnt_reg   <= 4'h0;
      shift_reg <= 16'h0000;
      addr_reg  <= 15'h0000;
    end else if (ce) begin
      sclk_reg <= sclk;
      if (csb_n) begin
        hdr_reg   <= 1'b0;
        cnt_reg   <= 4'h0;
        fresh_reg <= 1'b0;
      end else if (rise) begin
        shift_reg <= {shift_reg[14:0], sdi};
        cnt_reg   <= (hdr_end | byte_end) ? 4'h0 : cnt_reg + 4'h1;
        if (hdr_end) begin
          hdr_reg   <= 1'b1;
          rw_reg    <= shift_reg[14];
          addr_reg  <= hdr_addr;
          fresh_reg <= 1'b1;
        end else if (byte_end) begin
          addr_reg  <= addr_next;
          fresh_reg <= 1'b1;
        end
      end else if (fall) begin
        fresh_reg <= 1'b0;
      end
    end
  end

  // read data shifts out msb first on falling edges
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sdo_sh_reg <= 8'h00;
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else if (ce) begin
      sdo_oe_reg <= !csb_n & hdr_reg & rw_reg;
      if (fall && fresh_reg) begin
        sdo_reg    <= rd_byte[7];
        sdo_sh_reg <= {rd_byte[6:0], 1'b0};
      end else if (fall) begin
        sdo_reg    <= sdo_sh_reg[7];
        sdo_sh_reg <= {sdo_sh_reg[6:0], 1'b0};
      end
    end
  end

  // reserved bits are stored as written but steer nothing, except config bits 7 and 4, which CONFIG_WMASK clears
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      config_reg   <= asr_pkg::CONFIG_RESET;
      user_cfg_reg <= asr_pkg::USER_RESET;
      ctrl_a_reg   <= asr_pkg::CTRL_A_RESET;
      ctrl_b_reg   <= asr_pkg::CTRL_B_RESET;
    end else if (ce && wr_stb) begin
      if (addr_reg == asr_pkg::ADDR_CONFIG)
        config_reg <= wdata & asr_pkg::CONFIG_WMASK;
      if (addr_reg == asr_pkg::ADDR_USER_CFG)
        user_cfg_reg <= wdata;
      if (addr_reg == asr_pkg::ADDR_CTRL_A)
        ctrl_a_reg <= wdata;
      if (addr_reg == asr_pkg::ADDR_CTRL_B)
        ctrl_b_reg <= wdata;
    end
  end

  // the host must set the receiver before the processor; no interlock here
  assign sdo                       = sdo_reg;
  assign sdo_oe                    = sdo_oe_reg;
  assign ref_receiver_enable       = ctrl_a_reg[asr_pkg::BIT_RECV_EN];
  assign ref_processor_enable      = ctrl_a_reg[asr_pkg::BIT_PROC_EN];
  assign ref_window_fine_steps     = ctrl_a_reg[asr_pkg::BIT_ZOOM];
  assign ref_delay_select          = ctrl_a_reg[3:0];
  assign device_clock_dc_pecl_mode = ctrl_b_reg[asr_pkg::BIT_CLK_PECL];
  assign ref_input_dc_pecl_mode    = ctrl_b_reg[asr_pkg::BIT_REF_PECL];
  assign ref_polarity_invert       = ctrl_b_reg[asr_pkg::BIT_INVERT];

  asr_ref_path u_ref (
    .mclk        (mclk),
    .rst_s_n     (rst_s_n),
    .ce          (ce),
    .ref_in      (ref_in),
    .recv_en     (ctrl_a_reg[asr_pkg::BIT_RECV_EN]),
    .proc_en     (ctrl_a_reg[asr_pkg::BIT_PROC_EN]),
    .invert      (ctrl_b_reg[asr_pkg::BIT_INVERT]),
    .ts_en       (ctrl_b_reg[asr_pkg::BIT_TS_EN]),
    .ts_global   (timestamp_output_enable),
    .decim_one   (decimation_is_one),
    .ref_aligned (ref_aligned),
    .ref_ts_lsb  (ref_timestamp_lsb)
  );

  // the maker low identity byte is checked at the pin, msb only, past the serializer
  id_fixed_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && fall && fresh_reg && addr_reg == asr_pkg::ADDR_MAKER_LO
      |=> sdo == MAKER_CODE[7])
    else $error("maker identity not fixed");
  hold_addr_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && byte_end && hold |=> addr_reg == $past(addr_reg))
    else $error("address moved while held");
  ascend_step_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    ce && byte_end && !hold && ascend
      |=> addr_reg == $past(addr_reg) + 15'h0001)
    else $error("address did not increment");
  descend_step_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    ce && byte_end && !hold && !ascend
      |=> addr_reg == $past(addr_reg) - 15'h0001)
    else $error("address did not decrement");
  ctrl_write_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    ce && wr_stb && addr_reg == asr_pkg::ADDR_CTRL_A
      |=> ref_delay_select == $past(wdata[3:0]))
    else $error("delay select not written");
  sdo_idle_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && csb_n |=> !sdo_oe)
    else $error("sdo driven while deselected");
  pos_read_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && fall && fresh_reg && addr_reg == asr_pkg::ADDR_POS_2
      |=> sdo == $past(ref_edge_position_status[23]))
    else $error("position status not readable");
  zoom_map_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && wr_stb && addr_reg == asr_pkg::ADDR_CTRL_A
      |=> ref_window_fine_steps == $past(wdata[4])
          && ref_processor_enable == $past(wdata[6]))
    else $error("control a bit mapping wrong");
  invert_write_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    ce && wr_stb && addr_reg == asr_pkg::ADDR_CTRL_B
      |=> ref_polarity_invert == $past(wdata[0]))
    else $error("polarity invert not written");
  pecl_write_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    ce && wr_stb && addr_reg == asr_pkg::ADDR_CTRL_B
      |=> device_clock_dc_pecl_mode == $past(wdata[2])
          && ref_input_dc_pecl_mode == $past(wdata[1]))
    else $error("pecl mode bits not written");
endmodule // asr_regs

/* File: verilog/asr_pkg.sv */
// Notes on behaviour
// - two fixed read-only identity words, writes ignored
// - hold clear: streaming address steps by ascend
// - hold set: streaming address stays constant
// - processor enable bit 6 gates aligned reference events, not the timestamp
// - receiver enable bit 5, off after reset
// - delay select bits 3:0 drive capture delay
// - reference on sample lsb when both stamps enabled
// - reference timestamp only with decimation one
// - bits 2,1 select dc pecl clock, reference
// - control b bit 0 inverts reference
// - ascend bit: 0 decrements, 1 increments, default 1
// - 24-bit edge position status readable
package asr_pkg;
  localparam int          ADDR_W        = 15;
  localparam logic [14:0] ADDR_CONFIG   = 15'h0000;
  localparam logic [14:0] ADDR_PROD_LO  = 15'h0004;
  localparam logic [14:0] ADDR_PROD_HI  = 15'h0005;
  localparam logic [14:0] ADDR_MAKER_LO = 15'h000c;
  localparam logic [14:0] ADDR_MAKER_HI = 15'h000d;
  localparam logic [14:0] ADDR_USER_CFG = 15'h0010;
  localparam logic [14:0] ADDR_CTRL_A   = 15'h0029;
  localparam logic [14:0] ADDR_CTRL_B   = 15'h002a;
  localparam logic [14:0] ADDR_POS_0    = 15'h002c;
  localparam logic [14:0] ADDR_POS_1    = 15'h002d;
  localparam logic [14:0] ADDR_POS_2    = 15'h002e;
  localparam logic [7:0]  CONFIG_RESET  = 8'h20;
  localparam logic [7:0]  CONFIG_WMASK  = 8'h6f;
  localparam logic [7:0]  CONFIG_RO_SET = 8'h10;
  localparam logic [7:0]  USER_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_B_RESET  = 8'h00;
  localparam int          BIT_ASCEND    = 5;
  localparam int          BIT_HOLD      = 0;
  localparam int          BIT_PROC_EN   = 6;
  localparam int          BIT_RECV_EN   = 5;
  localparam int          BIT_ZOOM      = 4;
  localparam int          BIT_TS_EN     = 3;
  localparam int          BIT_CLK_PECL  = 2;
  localparam int          BIT_REF_PECL  = 1;
  localparam int          BIT_INVERT    = 0;
  localparam logic [3:0]  HDR_LAST      = 4'hf;
  localparam logic [3:0]  BYTE_LAST     = 4'h7;
endpackage

/* File: verilog/asr_ref_path.sv */
`timescale 1ns/1ps
module asr_ref_path (
  input  wire logic mclk,
  input  wire logic rst_s_n,
  input  wire logic ce,
  input  wire logic ref_in,
  input  wire logic recv_en,
  input  wire logic proc_en,
  input  wire logic invert,
  input  wire logic ts_en,
  input  wire logic ts_global,
  input  wire logic decim_one,
  output logic      ref_aligned,
  output logic      ref_ts_lsb
);
  logic ref_pol;
  logic aligned_next;
  logic ts_next;

  assign ref_pol      = ref_in ^ invert;
  // receiver off means no reference reaches either path
  assign aligned_next = recv_en & proc_en & ref_pol;
  assign ts_next      = recv_en & ts_en & ts_global
                      & decim_one & ref_pol;

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ref_aligned <= 1'b0;
      ref_ts_lsb  <= 1'b0;
    end else if (ce) begin
      ref_aligned <= aligned_next;
      ref_ts_lsb  <= ts_next;
    end
  end

  proc_gate_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && !proc_en |=> !ref_aligned)
    else $error("reference passed with processor disabled");
  invert_path_a: assert property (
    @(posedge mclk) disable iff (!rst_s_n)
    ce && recv_en && proc_en |=> ref_aligned == $past(ref_in ^ invert))
    else $error("aligned reference polarity wrong");
  ts_decim_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && !decim_one |=> !ref_ts_lsb)
    else $error("reference timestamp outside decimation one");
endmodule // asr_ref_path

/* File: sim/asr_host_model.sv */
`timescale 1ns/1ps
module asr_host_model (
  input  wire logic mclk,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk  = 1'b0;
    csb_n = 1'b1;
    sdi   = 1'b0;
  end
  // sclk held low three cycles so sdo has settled before the rise
  task automatic bit_io(input logic b, output logic q);
    @(negedge mclk);
    sclk = 1'b0;
    sdi  = b;
    repeat (3) @(negedge mclk);
    q    = sdo;
    sclk = 1'b1;
  endtask
  // header then n whole bytes, msb first, streaming
  task automatic frame(input logic rw, input logic [14:0] a, input int n,
                       input logic [31:0] wd, output logic [31:0] rd);
    logic        q;
    logic [15:0] hdr;
    hdr = {rw, a};
    rd  = 32'h0;
    @(negedge mclk);
    csb_n = 1'b0;
    for (int i = 15; i >= 0; i--) bit_io(hdr[i], q);
    for (int i = 31; i >= 32 - 8 * n; i--) begin
      bit_io(wd[i], q);
      rd[i] = q;
    end
    @(negedge mclk);
    csb_n = 1'b1;
    sdi   = ~sdi;
    @(negedge mclk);
    sclk = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
endmodule // asr_host_model

/* File: sim/test_adc_id_and_sysref_ctrl_regs.sv */
`timescale 1ns/1ps
module test_adc_id_and_sysref_ctrl_regs;
  localparam logic [15:0] PROD  = 16'h3c96; // arbitrary value
  localparam logic [15:0] MAKER = 16'h81e4; // arbitrary value
  logic        mclk, rst_n, ce, sclk, csb_n, sdi, sdo, sdo_oe, ref_in;
  logic        ts_glb, dec1, recv, proc, zoom, clk_pecl, ref_pecl, inv;
  logic        aligned, ts_lsb;
  logic [3:0]  dly;
  logic [23:0] pos;
  logic [31:0] rd;
  logic [7:0]  ctl_a;
  logic [7:0]  ctl_b;
  int          fails, samples_checked, cycles;
  int          oe_cycles = 0;
  assign ctl_a = {1'b0, proc, recv, zoom, dly};
  assign ctl_b = {5'h00, clk_pecl, ref_pecl, inv};
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  asr_regs #(.PRODUCT_CODE(PROD), .MAKER_CODE(MAKER)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .csb_n(csb_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ref_in(ref_in),
    .ref_edge_position_status(pos), .timestamp_output_enable(ts_glb),
    .decimation_is_one(dec1), .ref_receiver_enable(recv),
    .ref_processor_enable(proc), .ref_window_fine_steps(zoom),
    .ref_delay_select(dly), .device_clock_dc_pecl_mode(clk_pecl),
    .ref_input_dc_pecl_mode(ref_pecl), .ref_polarity_invert(inv),
    .ref_aligned(aligned), .ref_timestamp_lsb(ts_lsb));
  asr_host_model i_host (
    .mclk(mclk), .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo));
  task automatic results();
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // sdo_oe must stay low for a whole write frame
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    int oe0;
    oe0 = oe_cycles;
    i_host.frame(1'b0, a, n, d, rd);
    chk("sdo_oe_cycles", 8'h00, 8'(oe_cycles - oe0));
  endtask
  task automatic rdc(input logic [14:0] a, input int n,
                     input logic [31:0] e, input string nm);
    int oe0;
    oe0 = oe_cycles;
    i_host.frame(1'b1, a, n, 32'h0, rd);
    for (int k = 0; k < n; k++) chk(nm, e[31-8*k -: 8], rd[31-8*k -: 8]);
    // host spends four mclk per bit; sdo_oe stands from header end to csb_n
    chk("sdo_oe_cycles", 8'(32 * n), 8'(oe_cycles - oe0));
  endtask
  // ref path is registered: two rising edges between stimulus and check
  task automatic ref_step(input logic r, input logic e, input logic et);
    ref_in = r;
    repeat (2) @(negedge mclk);
    chk("ref_aligned", {7'h00, e}, {7'h00, aligned});
    chk("ref_ts_lsb", {7'h00, et}, {7'h00, ts_lsb});
  endtask
  always @(negedge mclk) begin
    if (sdo_oe === 1'b1) oe_cycles++;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 12000) begin
      fails++;
      results();
    end
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    ref_in = 1'b0;
    pos = 24'hc3a51e;
    ts_glb = 1'b0;
    dec1 = 1'b0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("ctrl_a_out", 8'h00, ctl_a);
    chk("ctrl_b_out", 8'h00, ctl_b);
    rdc(asr_pkg::ADDR_CONFIG, 1, 32'h30000000, "config");
    rdc(asr_pkg::ADDR_USER_CFG, 1, 32'h0, "user_cfg");
    rdc(asr_pkg::ADDR_CTRL_A, 2, 32'h0, "ctrl_ab");
    wr(asr_pkg::ADDR_PROD_LO, 2, 32'h00ff0000);
    wr(asr_pkg::ADDR_MAKER_LO, 2, 32'h00ff0000);
    rdc(asr_pkg::ADDR_PROD_LO, 2, {PROD[7:0], PROD[15:8], 16'h0},
        "prod");
    rdc(asr_pkg::ADDR_MAKER_LO, 2, {MAKER[7:0], MAKER[15:8], 16'h0},
        "mk");
    ref_step(1'b1, 1'b0, 1'b0);
    wr(asr_pkg::ADDR_CTRL_A, 1, 32'h20000000);
    ref_step(1'b1, 1'b0, 1'b0);
    wr(asr_pkg::ADDR_CTRL_A, 1, 32'h65000000);
    chk("ctrl_a_out", 8'h65, ctl_a);
    ref_step(1'b1, 1'b1, 1'b0);
    // clock enable low freezes the aligned output
    ce = 1'b0;
    ref_step(1'b0, 1'b1, 1'b0);
    ce = 1'b1;
    ref_step(1'b0, 1'b0, 1'b0);
    wr(asr_pkg::ADDR_CTRL_B, 1, 32'h01000000);
    chk("ctrl_b_out", 8'h01, ctl_b);
    ref_step(1'b1, 1'b0, 1'b0);
    ref_step(1'b0, 1'b1, 1'b0);
    wr(asr_pkg::ADDR_CTRL_B, 1, 32'hfe000000);
    chk("ctrl_b_out", 8'h06, ctl_b);
    rdc(asr_pkg::ADDR_CTRL_B, 1, 32'hfe000000, "ctrl_b");
    ts_glb = 1'b1;
    dec1 = 1'b1;
    ref_step(1'b1, 1'b1, 1'b1);
    dec1 = 1'b0;
    ref_step(1'b1, 1'b1, 1'b0);
    dec1 = 1'b1;
    ts_glb = 1'b0;
    ref_step(1'b1, 1'b1, 1'b0);
    wr(asr_pkg::ADDR_CTRL_A, 1, 32'h9a000000);
    chk("ctrl_a_out", 8'h1a, ctl_a);
    rdc(asr_pkg::ADDR_CTRL_A, 1, 32'h9a000000, "ctrl_a");
    ref_step(1'b1, 1'b0, 1'b0);
    wr(asr_pkg::ADDR_CTRL_A, 2, 32'h21060000);
    chk("ctrl_a_out", 8'h21, ctl_a);
    chk("ctrl_b_out", 8'h06, ctl_b);
    wr(asr_pkg::ADDR_CONFIG, 1, 32'h00000000);
    rdc(asr_pkg::ADDR_CONFIG, 1, 32'h10000000, "config");
    rdc(asr_pkg::ADDR_CTRL_B, 2, 32'h06210000, "descend");
    wr(asr_pkg::ADDR_CONFIG, 1, 32'h20000000);
    wr(asr_pkg::ADDR_USER_CFG, 1, 32'h01000000);
    wr(asr_pkg::ADDR_CTRL_A, 2, 32'h33440000);
    chk("ctrl_a_out", 8'h44, ctl_a);
    chk("ctrl_b_out", 8'h06, ctl_b);
    rdc(asr_pkg::ADDR_CTRL_A, 2, 32'h44440000, "hold");
    wr(asr_pkg::ADDR_USER_CFG, 1, 32'h00000000);
    rdc(asr_pkg::ADDR_POS_0, 3, 32'h1ea5c300, "position");
    rdc(15'h007f, 1, 32'h0, "unmapped");
    // mid-run reset must bring every writable field back to its default
    wr(asr_pkg::ADDR_CONFIG, 1, 32'h00000000);
    wr(asr_pkg::ADDR_USER_CFG, 1, 32'h80000000);
    rst_n = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("ctrl_a_out", 8'h00, ctl_a);
    chk("ctrl_b_out", 8'h00, ctl_b);
    rdc(asr_pkg::ADDR_CONFIG, 1, 32'h30000000, "config");
    rdc(asr_pkg::ADDR_USER_CFG, 1, 32'h0, "user_cfg");
    results();
  end
endmodule // test_adc_id_and_sysref_ctrl_regs
